// ---- rtl/dpim_pkg.sv ----
package dpim_pkg;

  // ----------------------------------------
  // sizes and timing
  // ----------------------------------------
  localparam int NIN = 4;
  localparam int NCH = 2;
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam logic [9:0] SETTLE_STEP_MS = 10'd10;
  localparam logic [9:0] SETTLE_MAX_MS = 10'd1000;
  localparam logic [23:0] WEIGHT_MAX = 24'd9999999;
  localparam logic [16:0] WEIGHT_SCALE = 17'd100000;
  localparam logic [16:0] DISP_WRAP = 17'd100000;
  localparam logic [4:0] UNIT_LAST = 5'd18;
  localparam logic [4:0] UNIT_LAST_TIMED = 5'd9;
  localparam logic [1:0] RATE_LAST = 2'd2;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_SETTLE0 = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h014;
  localparam logic [11:0] OFS_NCOUNT0 = 12'h020;
  localparam logic [11:0] OFS_SYNCCNT = 12'h030;
  localparam logic [11:0] OFS_CH0 = 12'h040;
  localparam logic [11:0] CH_STRIDE = 12'h020;
  localparam logic [11:0] OFS_CH_CFG = 12'h000;
  localparam logic [11:0] OFS_CH_WEIGHT = 12'h004;
  localparam logic [11:0] OFS_CH_COUNT = 12'h008;
  localparam logic [11:0] OFS_CH_QTY = 12'h00c;
  localparam logic [11:0] OFS_CH_DISP = 12'h010;

  // field positions
  localparam int CTRL_HI_EN_BIT = 8;
  localparam int STATUS_REJECT_BIT = 8;
  localparam int CFG_TRANS_BIT = 4;
  localparam int CFG_UNIT_LSB = 5;
  localparam int CFG_RATE_LSB = 10;

  // reset values
  localparam logic [9:0] SETTLE_RST = 10'd0;
  localparam logic [1:0] MODE_RST = 2'd0;

  // input control modes
  localparam logic [1:0] MODE_NORMAL = 2'd0;
  localparam logic [1:0] MODE_DSYNC = 2'd1;
  localparam logic [1:0] MODE_METER = 2'd2;
  localparam logic [1:0] MODE_TARIFF = 2'd3;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] sync;
    logic level;
    logic [9:0] held_ms;
    logic rise;
    logic fall;
  } dpim_settle_t;

  typedef struct packed {
    logic [3:0] mask;
    logic trans;
    logic [4:0] unit;
    logic [1:0] rate;
    logic [23:0] weight;
    logic [31:0] count;
    logic [31:0] qty;
    logic [16:0] disp;
  } dpim_chan_t;

  typedef enum logic [1:0] {DIV_IDLE, DIV_QTY, DIV_DISP} dpim_div_t;

  typedef struct packed {
    logic [16:0] prescale;
    logic tick;
    logic [NIN-1:0][1:0] mode;
    logic hi_en;
    logic [NIN-1:0][9:0] settle;
    logic reject;
    logic [NIN-1:0][31:0] norm_cnt;
    logic [31:0] sync_cnt;
    logic sync_pulse;
    logic [NIN-1:0] tariff;
    logic [NIN-1:0] armed;
    dpim_chan_t [NCH-1:0] ch;
    dpim_div_t div;
    logic div_ch;
    logic [5:0] div_idx;
    logic [48:0] div_num;
    logic [23:0] div_den;
    logic [49:0] div_rem;
    logic [48:0] div_quo;
    logic [31:0] prdata;
  } dpim_state_t;

endpackage

// ---- rtl/dpim_settle.sv ----
module dpim_settle (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // timing and setting
  input wire logic ms_tick,
  input wire logic [9:0] settle_ms,
  // raw pin
  input wire logic raw_in,
  // filtered result
  output logic level,
  output logic rise,
  output logic fall
);
  import dpim_pkg::*;

  dpim_settle_t r_reg;
  dpim_settle_t r_next;

  // only sync[1] is looked at; sync[0] feeds nothing else
  always_comb begin
    r_next = r_reg;
    r_next.sync = {r_reg.sync[0], raw_in};
    r_next.rise = 1'b0;
    r_next.fall = 1'b0;
    if (r_reg.sync[1] == r_reg.level) begin
      r_next.held_ms = 10'd0;
    end else if (settle_ms == 10'd0 ||
                 (ms_tick && (r_reg.held_ms + 10'd1) >= settle_ms)) begin
      // one ms tick of granularity: the hold may fall up to a ms short
      r_next.level = r_reg.sync[1];
      r_next.rise = r_reg.sync[1];
      r_next.fall = ~r_reg.sync[1];
      r_next.held_ms = 10'd0;
    end else if (ms_tick) begin
      r_next.held_ms = r_reg.held_ms + 10'd1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign level = r_reg.level;
  assign rise = r_reg.rise;
  assign fall = r_reg.fall;
endmodule

// ---- rtl/dpim_top.sv ----
// The placing of the registers and the APB register port are this design's own decisions.
module dpim_top #(
  parameter int CYC_PER_MS = dpim_pkg::MS_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // status input pins
  input wire logic status_input_one,
  input wire logic status_input_two,
  input wire logic status_input_three,
  input wire logic status_input_four,
  // meter function outputs
  output logic demand_sync_pulse,
  output logic [dpim_pkg::NIN-1:0] tariff_select,
  output logic [dpim_pkg::NIN-1:0] status_level
);
  import dpim_pkg::*;

  // ----------------------------------------
  // debounce filters
  // ----------------------------------------
  dpim_state_t r_reg;
  dpim_state_t r_next;
  logic [NIN-1:0] raw;
  logic [NIN-1:0] lvl;
  logic [NIN-1:0] rise;
  logic [NIN-1:0] fall;

  assign raw = {status_input_four, status_input_three, status_input_two, status_input_one};

  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_in
      // filtering sits ahead of all mode logic
      dpim_settle u_settle (
        .pclk(pclk),
        .presetn(presetn),
        .ms_tick(r_reg.tick),
        .settle_ms(r_reg.settle[gi]),
        .raw_in(raw[gi]),
        .level(lvl[gi]),
        .rise(rise[gi]),
        .fall(fall[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // register file, counting and divider
  // ----------------------------------------
  logic wr;
  logic rd;
  logic hit;
  logic bad;
  logic [NIN-1:0] en;
  logic [NIN-1:0] ev_rise;
  logic [NIN-1:0] ev_fall;
  logic [NIN-1:0] done;
  logic [2:0] inc;
  logic [31:0] rdata;
  logic [11:0] cb;
  logic [4:0] unit_w;
  logic [1:0] rate_w;
  logic [49:0] trial;

  always_comb begin
    r_next = r_reg;
    wr = psel && penable && pwrite;
    rd = psel && !penable && !pwrite;
    hit = 1'b0;
    bad = 1'b0;
    rdata = 32'h0000_0000;
    inc = 3'd0;
    cb = 12'h000;
    unit_w = pwdata[CFG_UNIT_LSB +: 5];
    rate_w = pwdata[CFG_RATE_LSB +: 2];
    trial = 50'h0;
    r_next.tick = 1'b0;
    r_next.sync_pulse = 1'b0;

    // millisecond time base for the filters
    if (r_reg.prescale == 17'(CYC_PER_MS - 1)) begin
      r_next.prescale = 17'h0;
      r_next.tick = 1'b1;
    end else begin
      r_next.prescale = r_reg.prescale + 17'h1;
    end

    // address decode; reads are latched in setup so prdata comes from a flop
    if (paddr == OFS_CTRL) begin
      hit = 1'b1;
      rdata = {23'h0, r_reg.hi_en, r_reg.mode};
      if (wr) begin
        r_next.mode = pwdata[7:0];
        r_next.hi_en = pwdata[CTRL_HI_EN_BIT];
      end
    end
    for (int i = 0; i < NIN; i++) begin
      if (paddr == OFS_SETTLE0 + 12'(4 * i)) begin
        hit = 1'b1;
        rdata = {22'h0, r_reg.settle[i]};
        if (wr) begin
          // off-step or oversize values leave the old setting in place
          if (pwdata[31:10] != 22'h0 || pwdata[9:0] > SETTLE_MAX_MS ||
              (pwdata[9:0] % SETTLE_STEP_MS) != 10'd0) begin
            bad = 1'b1;
          end else begin
            r_next.settle[i] = pwdata[9:0];
          end
        end
      end
      if (paddr == OFS_NCOUNT0 + 12'(4 * i)) begin
        hit = 1'b1;
        rdata = r_reg.norm_cnt[i];
        if (wr) begin
          r_next.norm_cnt[i] = 32'h0;
        end
      end
    end
    if (paddr == OFS_STATUS) begin
      hit = 1'b1;
      rdata = {23'h0, r_reg.reject, 4'h0, lvl};
      if (wr && pwdata[STATUS_REJECT_BIT]) begin
        r_next.reject = 1'b0;
      end
    end
    if (paddr == OFS_SYNCCNT) begin
      hit = 1'b1;
      rdata = r_reg.sync_cnt;
      if (wr) begin
        r_next.sync_cnt = 32'h0;
      end
    end
    for (int c = 0; c < NCH; c++) begin
      cb = OFS_CH0 + 12'(c) * CH_STRIDE;
      if (paddr == cb + OFS_CH_CFG) begin
        hit = 1'b1;
        rdata = {20'h0, r_reg.ch[c].rate, r_reg.ch[c].unit, r_reg.ch[c].trans,
                 r_reg.ch[c].mask};
        if (wr) begin
          if (unit_w > UNIT_LAST || rate_w > RATE_LAST) begin
            bad = 1'b1;
          end else begin
            r_next.ch[c].mask = pwdata[3:0];
            r_next.ch[c].trans = pwdata[CFG_TRANS_BIT];
            r_next.ch[c].unit = unit_w;
            // energy units imply their demand unit; the rate field is forced
            if (unit_w != 5'd0 && unit_w <= UNIT_LAST_TIMED) begin
              r_next.ch[c].rate = 2'd0;
            end else begin
              r_next.ch[c].rate = rate_w;
            end
          end
        end
      end
      if (paddr == cb + OFS_CH_WEIGHT) begin
        hit = 1'b1;
        rdata = {8'h0, r_reg.ch[c].weight};
        if (wr) begin
          if (pwdata > 32'(WEIGHT_MAX)) begin
            bad = 1'b1;
          end else begin
            r_next.ch[c].weight = pwdata[23:0];
          end
        end
      end
      if (paddr == cb + OFS_CH_COUNT) begin
        hit = 1'b1;
        rdata = r_reg.ch[c].count;
        if (wr) begin
          r_next.ch[c].count = 32'h0;
        end
      end
      if (paddr == cb + OFS_CH_QTY) begin
        hit = 1'b1;
        rdata = r_reg.ch[c].qty;
      end
      if (paddr == cb + OFS_CH_DISP) begin
        hit = 1'b1;
        rdata = {15'h0, r_reg.ch[c].disp};
      end
    end
    if (rd) begin
      r_next.prdata = rdata;
    end

    // a refused write is remembered until software clears it; set wins
    if (wr && bad) begin
      r_next.reject = 1'b1;
    end

    // ----------------------------------------
    // input events; hardware updates follow the writes so they win
    // ----------------------------------------
    en = {r_reg.hi_en, r_reg.hi_en, 2'b11};
    ev_rise = rise & en;
    ev_fall = fall & en;
    done = ev_fall & r_reg.armed;
    for (int i = 0; i < NIN; i++) begin
      if (ev_rise[i]) begin
        r_next.armed[i] = 1'b1;
      end else if (ev_fall[i]) begin
        r_next.armed[i] = 1'b0;
      end
      if (r_reg.mode[i] == MODE_NORMAL && ev_rise[i]) begin
        r_next.norm_cnt[i] = r_next.norm_cnt[i] + 32'h1;
      end
      if (r_reg.mode[i] == MODE_DSYNC && ev_rise[i]) begin
        r_next.sync_pulse = 1'b1;
      end
      r_next.tariff[i] = (r_reg.mode[i] == MODE_TARIFF) && lvl[i] && en[i];
    end
    if (r_next.sync_pulse) begin
      r_next.sync_cnt = r_next.sync_cnt + 32'h1;
    end
    for (int c = 0; c < NCH; c++) begin
      inc = 3'd0;
      for (int i = 0; i < NIN; i++) begin
        // only inputs in metering mode feed the channels
        if (r_reg.ch[c].mask[i] && r_reg.mode[i] == MODE_METER) begin
          if (r_reg.ch[c].trans) begin
            inc = inc + 3'(ev_rise[i] | ev_fall[i]);
          end else begin
            inc = inc + 3'(done[i]);
          end
        end
      end
      r_next.ch[c].count = r_next.ch[c].count + 32'(inc);
    end

    // ----------------------------------------
    // shared divider: quantity, then readout wrap
    // ----------------------------------------
    case (r_reg.div)
      DIV_IDLE: begin
        r_next.div_idx = 6'd48;
        r_next.div_rem = 50'h0;
        r_next.div_quo = 49'h0;
        r_next.div_num = 49'(r_reg.ch[r_reg.div_ch].count) * 49'(WEIGHT_SCALE);
        r_next.div_den = r_reg.ch[r_reg.div_ch].weight;
        if (r_reg.ch[r_reg.div_ch].weight == 24'h0) begin
          r_next.ch[r_reg.div_ch].qty = 32'h0;
          r_next.ch[r_reg.div_ch].disp = 17'h0;
          r_next.div_ch = ~r_reg.div_ch;
        end else begin
          r_next.div = DIV_QTY;
        end
      end
      DIV_QTY, DIV_DISP: begin
        trial = {r_reg.div_rem[48:0], r_reg.div_num[r_reg.div_idx]};
        if (trial >= 50'(r_reg.div_den)) begin
          trial = trial - 50'(r_reg.div_den);
          r_next.div_quo[r_reg.div_idx] = 1'b1;
        end
        r_next.div_rem = trial;
        r_next.div_idx = r_reg.div_idx - 6'd1;
        if (r_reg.div_idx == 6'd0) begin
          // the last quotient bit lands in r_next this cycle, so read it before clearing
          r_next.div_idx = 6'd48;
          r_next.div_rem = 50'h0;
          if (r_reg.div == DIV_QTY) begin
            // count times scale over weight gives whole units
            r_next.ch[r_reg.div_ch].qty = r_next.div_quo[31:0];
            r_next.div_num = {17'h0, r_next.div_quo[31:0]};
            r_next.div_den = 24'(DISP_WRAP);
            r_next.div = DIV_DISP;
          end else begin
            r_next.ch[r_reg.div_ch].disp = trial[16:0];
            r_next.div_ch = ~r_reg.div_ch;
            r_next.div = DIV_IDLE;
          end
          r_next.div_quo = 49'h0;
        end
      end
      default: begin
        r_next.div = DIV_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
      r_reg.mode <= {NIN{MODE_RST}};
      r_reg.settle <= {NIN{SETTLE_RST}};
      r_reg.div <= DIV_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata = r_reg.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && (!hit || (pwrite && bad));
  assign demand_sync_pulse = r_reg.sync_pulse;
  assign tariff_select = r_reg.tariff;
  assign status_level = lvl;
endmodule

// ---- sim/dpim_top_asserts.sv ----
module dpim_top_checker #(
  parameter int CYC_PER_MS = dpim_pkg::MS_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins and meter functions
  input wire logic status_input_one,
  input wire logic status_input_two,
  input wire logic demand_sync_pulse,
  input wire logic [dpim_pkg::NIN-1:0] tariff_select,
  input wire logic [dpim_pkg::NIN-1:0] status_level
);
  import dpim_pkg::*;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------
  // bus
  // ----------------------------------------
  a_ready_high: assert property (pready) else $error("ready dropped");
  a_err_access: assert property (pslverr |-> psel && penable) else $error("stray slave error");
  a_unmapped_err: assert property (psel && penable && paddr == 12'h018 |->
    pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped access accepted");
  // read data may only move when a setup cycle was seen
  a_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data moved");

  // ----------------------------------------
  // filtered inputs
  // ----------------------------------------
  a_level_rise: assert property ($rose(status_level[0]) |->
    $past(status_input_one, 2) && $past(status_input_one, 3)) else $error("early rise");
  a_level_fall: assert property ($fell(status_level[1]) |->
    !$past(status_input_two, 2) && !$past(status_input_two, 3)) else $error("early fall");
  a_sync_single: assert property (demand_sync_pulse |=> !demand_sync_pulse)
    else $error("sync pulse too long");
  a_sync_cause: assert property (demand_sync_pulse |->
    (($past(status_level) & ~$past(status_level, 2)) |
    ($past(status_level, 2) & ~$past(status_level, 3))) != 4'h0) else $error("sync w/o rise");
  a_tariff_level: assert property (
    (tariff_select & ~status_level & ~$past(status_level)) == 4'h0) else $error("tariff w/o level");

  c_sync: cover property (demand_sync_pulse);
  c_rise: cover property ($rose(status_level[0]));
  c_tariff: cover property (tariff_select != 4'h0);
  c_err: cover property (pslverr);
endmodule

bind dpim_top dpim_top_checker #(.CYC_PER_MS(CYC_PER_MS)) i_dpim_top_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .status_input_one(status_input_one), .status_input_two(status_input_two),
  .demand_sync_pulse(demand_sync_pulse), .tariff_select(tariff_select),
  .status_level(status_level)
);

// ---- sim/dpim_contacts.sv ----
module dpim_contacts (
  // clock
  input wire logic pclk,
  // wanted contact state and chatter length
  input wire logic [3:0] want,
  input wire logic [7:0] bounce,
  // contact levels at the pins
  output logic [3:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] rest = 4'h0;
  logic [7:0] left = 8'h00;

  initial pins = 4'h0;
  // a moving contact chatters every cycle before it rests, the worst a filter meets
  always @(posedge pclk) begin
    if (want != rest) begin
      if (left < bounce) begin
        pins <= pins ^ (want ^ rest);
        left <= left + 8'h01;
      end else begin
        pins <= want;
        rest <= want;
        left <= 8'h00;
      end
    end
  end
endmodule

// ---- sim/dpim_top_test.sv ----
module dpim_top_test;
  import dpim_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, n1, n2, n3, q;
  logic pready, pslverr, sync_pulse;
  logic [3:0] tariff_select, status_level, pins, want = 4'h0;
  logic [7:0] bounce = 8'h00;
  logic [33:0] exp_q[$], cur;
  integer seed = 32'h4fe3;
  int n_fail = 0, n_tests = 0;

`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  dpim_top #(.CYC_PER_MS(10)) i_dpim_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .status_input_one(pins[0]),
    .status_input_two(pins[1]), .status_input_three(pins[2]), .status_input_four(pins[3]),
    .demand_sync_pulse(sync_pulse), .tariff_select(tariff_select),
    .status_level(status_level));
  dpim_contacts i_dpim_contacts (.pclk(pclk), .want(want), .bounce(bounce), .pins(pins));

  // ----------------------------------------
  // bus master and result monitor
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [31:0] e, input logic err);
    exp_q.push_back({~w, err, e});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  always @(posedge pclk) begin
    if (presetn && psel && penable && pready === 1'b1) begin
      cur = exp_q.pop_front();
      `CHK(pslverr, cur[32])
      if (cur[33]) `CHK(prdata, cur[31:0])
    end
  end

  task automatic pulse(input int i, input logic [31:0] n, input int hold);
    repeat (n) begin
      want[i] <= 1'b1;
      repeat (hold) @(posedge pclk);
      want[i] <= 1'b0;
      repeat (hold) @(posedge pclk);
    end
  endtask

  task finish_test;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge pclk);
    n_fail++;
    $display("unexpected at %0t: run hung", $time);
    finish_test;
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(0, OFS_CTRL, 0, 0, 0);
    xfer(0, OFS_SETTLE0, 0, 0, 0);
    xfer(0, 12'h018, 0, 0, 1);
    // one normal, two demand sync, three metering, four tariff
    xfer(1, OFS_CTRL, 32'h1e4, 0, 0);
    xfer(0, OFS_CTRL, 0, 32'h1e4, 0);
    xfer(1, OFS_CH0, 32'h4, 0, 0);
    xfer(1, OFS_CH0 + CH_STRIDE, 32'h14, 0, 0);
    n1 = ($random(seed) & 3) + 1;
    n2 = ($random(seed) & 3) + 1;
    n3 = ($random(seed) & 3) + 1;
    pulse(0, n1, 6);
    pulse(1, n2, 6);
    pulse(2, n3, 6);
    want <= 4'b1100;
    repeat (8) @(posedge pclk);
    `CHK(tariff_select, 4'b1000)
    xfer(0, OFS_NCOUNT0, 0, n1, 0);
    xfer(0, OFS_NCOUNT0 + 12'h008, 0, 0, 0);
    xfer(0, OFS_SYNCCNT, 0, n2, 0);
    xfer(0, OFS_CH0 + OFS_CH_COUNT, 0, n3, 0);
    xfer(0, OFS_CH0 + CH_STRIDE + OFS_CH_COUNT, 0, 2 * n3 + 1, 0);
    want <= 4'b0000;
    repeat (8) @(posedge pclk);
    `CHK(tariff_select, 4'b0000)
    xfer(1, OFS_CTRL, 32'h1e6, 0, 0);
    xfer(1, OFS_CH0, 32'h5, 0, 0);
    want <= 4'b0101;
    repeat (8) @(posedge pclk);
    want <= 4'b0000;
    repeat (8) @(posedge pclk);
    xfer(1, OFS_CTRL, 32'h0e6, 0, 0);
    pulse(2, 1, 6);
    xfer(0, OFS_CH0 + OFS_CH_COUNT, 0, n3 + 3, 0);
    xfer(1, OFS_CH0 + OFS_CH_WEIGHT, 32'd10000000, 0, 1);
    xfer(1, OFS_CH0 + OFS_CH_WEIGHT, 32'd3, 0, 0);
    repeat (400) @(posedge pclk);
    q = (n3 + 3) * 32'd100000 / 32'd3;
    xfer(0, OFS_CH0 + OFS_CH_QTY, 0, q, 0);
    xfer(0, OFS_CH0 + OFS_CH_DISP, 0, q % 32'd100000, 0);
    xfer(1, OFS_CH0 + CH_STRIDE, 32'h274, 0, 1);
    xfer(1, OFS_CH0 + CH_STRIDE, 32'h834, 0, 0);
    xfer(0, OFS_CH0 + CH_STRIDE, 0, 32'h34, 0);
    xfer(1, OFS_CH0 + CH_STRIDE, 32'h554, 0, 0);
    xfer(0, OFS_CH0 + CH_STRIDE, 0, 32'h554, 0);
    xfer(1, OFS_CTRL, 32'h1e4, 0, 0);
    xfer(1, OFS_SETTLE0, 32'd15, 0, 1);
    xfer(0, OFS_STATUS, 0, 32'h100, 0);
    xfer(1, OFS_STATUS, 32'h100, 0, 0);
    xfer(1, OFS_SETTLE0, 32'd1010, 0, 1);
    xfer(1, OFS_SETTLE0, 32'd1000, 0, 0);
    xfer(0, OFS_SETTLE0, 0, 32'd1000, 0);
    xfer(1, OFS_SETTLE0, 32'd10, 0, 0);
    xfer(1, OFS_NCOUNT0, 0, 0, 0);
    // chatter, then a glitch shorter than the settle time, then a real pulse
    bounce <= 8'd20;
    pulse(0, 1, 60);
    pulse(0, 1, 130);
    xfer(0, OFS_NCOUNT0, 0, 1, 0);
    finish_test;
  end
endmodule
